// file: design/mcp_core.sv
// Top of the motor control PWM core: registers, channels, faults, outputs.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module mcp_core
  import mcp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [1:0] fault_in,
  input  wire logic [2:0] current_sense_in,
  output logic      [7:0] rdata_out,
  output logic      [5:0] pwm_out,
  output logic            irq_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       main_ctl;
    logic [7:0]       sec_ctl;
    logic [7:0]       fault_ctl;
    logic [7:0]       manual;
    logic [7:0]       dead;
    logic [7:0]       cfg;
    logic [7:0]       int_sts;
    logic [7:0]       int_mask;
    logic [11:0]      modulo;
    logic [5:0][15:0] val_buf;
    logic [5:0][15:0] val_act;
    logic [1:0]       fflag;
    logic [7:0]       rdata;
    logic [5:0]       pwm;
    logic             irq;
  } mcp_state_type;

  mcp_state_type s_q, s_d;
  mcp_tb_if      tb ();

  logic [5:0] raw;
  logic [2:0] pair_top;
  logic [2:0] dt_top;
  logic [2:0] dt_bot;
  logic [2:0] corr_sel;

  assign rdata_out = s_q.rdata;
  assign pwm_out   = s_q.pwm;
  assign irq_out   = s_q.irq;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  assign tb.enable   = s_q.main_ctl[MAIN_ENABLE_BIT];
  assign tb.center   = s_q.cfg[CFG_CENTER_BIT];
  assign tb.prescale = s_q.sec_ctl[SEC_PRESCALE_LO +: 2];
  assign tb.modulo   = s_q.modulo;

  mcp_timebase u_timebase (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .tb        (tb.src)
  );

  // ----------------------------------------------------------------
  // Channel compare
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chan
      // Negative values give zero width; large values give full width.
      assign raw[gi] = ~s_q.val_act[gi][15]
                       & ({4'h0, tb.count} < s_q.val_act[gi]);
    end
    for (gi = 0; gi < 3; gi++) begin : g_pair
      assign corr_sel[gi] = s_q.cfg[CFG_SENSE_BIT] ? current_sense_in[gi]
                            : s_q.sec_ctl[SEC_CORR_LO + gi];
      assign pair_top[gi] = corr_sel[gi] ? raw[2 * gi + 1] : raw[2 * gi];
      mcp_deadtime u_dead (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .top_in    (pair_top[gi]),
        .dead_in   (s_q.dead),
        .top_out   (dt_top[gi]),
        .bot_out   (dt_bot[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] level;
    logic [1:0] fset;
    logic       ld_wr;
    logic       fault_off;
    logic [7:0] rsel;
    logic [3:0] vidx;
    level = '0;
    fset = '0;
    ld_wr = 1'b0;
    fault_off = 1'b0;
    rsel = '0;
    vidx = '0;
    s_d = s_q;

    // Register writes.
    if (wr_in) begin
      case (addr_in)
        ADDR_MAIN_CTL: begin
          s_d.main_ctl = wdata_in & 8'h03;
          ld_wr = wdata_in[MAIN_LOAD_BIT];
        end
        ADDR_SEC_CTL: begin
          s_d.sec_ctl = wdata_in & SEC_MASK;
        end
        ADDR_FAULT_CTL: begin
          s_d.fault_ctl = wdata_in;
        end
        ADDR_FAULT_ACK: begin
          if (wdata_in[FLT1_ACK_BIT]) begin
            s_d.fflag[0] = 1'b0;
          end
          if (wdata_in[FLT4_ACK_BIT]) begin
            s_d.fflag[1] = 1'b0;
          end
        end
        ADDR_MANUAL: begin
          s_d.manual = wdata_in & 8'h7f;
        end
        ADDR_MOD_HI: begin
          s_d.modulo[11:8] = wdata_in[3:0];
        end
        ADDR_MOD_LO: begin
          s_d.modulo[7:0] = wdata_in;
        end
        ADDR_DEADTIME: begin
          s_d.dead = wdata_in;
        end
        ADDR_CONFIG: begin
          s_d.cfg = wdata_in & 8'h0f;
        end
        ADDR_INT_STS: begin
          s_d.int_sts = s_q.int_sts & ~wdata_in;
        end
        ADDR_INT_MASK: begin
          s_d.int_mask = wdata_in & INT_MASK_ALL;
        end
        default: begin
          if (addr_in >= ADDR_VAL_BASE && addr_in <= ADDR_VAL_LAST) begin
            vidx = 4'(addr_in - ADDR_VAL_BASE);
            if (vidx[0]) begin
              s_d.val_buf[vidx[3:1]][7:0] = wdata_in;
            end else begin
              s_d.val_buf[vidx[3:1]][15:8] = wdata_in;
            end
          end
        end
      endcase
    end

    // Buffered values take effect at a period start once load is permitted.
    if (tb.start) begin
      s_d.int_sts[INT_RELOAD_BIT] = 1'b1;
      if (s_q.main_ctl[MAIN_LOAD_BIT]) begin
        s_d.val_act = s_q.val_buf;
        s_d.main_ctl[MAIN_LOAD_BIT] = ld_wr;
      end
    end

    // Fault flags: the set wins over an acknowledge in the same cycle.
    fset[0] = fault_in[0] & s_q.fault_ctl[FLT1_EN_BIT];
    fset[1] = fault_in[1] & s_q.fault_ctl[FLT4_EN_BIT];
    s_d.fflag = s_d.fflag | fset;
    if (fset[0] & ~s_q.fflag[0]) begin
      s_d.int_sts[INT_FLT1_BIT] = 1'b1;
    end
    if (fset[1] & ~s_q.fflag[1]) begin
      s_d.int_sts[INT_FLT4_BIT] = 1'b1;
    end
    fault_off = |s_q.fflag;

    // Output selection.
    if (s_q.cfg[CFG_INDEP_BIT]) begin
      level = raw;
    end else begin
      for (int i = 0; i < 3; i++) begin
        level[2 * i]     = dt_top[i];
        level[2 * i + 1] = dt_bot[i];
      end
    end
    if (!s_q.main_ctl[MAIN_ENABLE_BIT]) begin
      level = '0;
    end
    if (s_q.manual[MAN_ENABLE_BIT]) begin
      level = s_q.manual[5:0];
    end
    if (fault_off) begin
      level = '0;
    end
    s_d.pwm = s_q.cfg[CFG_POL_BIT] ? ~level : level;

    // Read path.
    if (rd_in) begin
      case (addr_in)
        ADDR_MAIN_CTL: begin
          rsel = s_q.main_ctl;
          rsel[MAIN_RELOAD_BIT] = s_q.int_sts[INT_RELOAD_BIT];
        end
        ADDR_SEC_CTL: begin
          rsel = s_q.sec_ctl;
        end
        ADDR_FAULT_CTL: begin
          rsel = s_q.fault_ctl;
        end
        ADDR_FAULT_STS: begin
          rsel[FLT1_FLAG_BIT] = s_q.fflag[0];
          rsel[FLT1_PIN_BIT]  = fault_in[0];
          rsel[FLT4_FLAG_BIT] = s_q.fflag[1];
          rsel[FLT4_PIN_BIT]  = fault_in[1];
        end
        ADDR_MANUAL: begin
          rsel = s_q.manual;
        end
        ADDR_CNT_HI: begin
          rsel = {4'h0, tb.count[11:8]};
        end
        ADDR_CNT_LO: begin
          rsel = tb.count[7:0];
        end
        ADDR_MOD_HI: begin
          rsel = {4'h0, s_q.modulo[11:8]};
        end
        ADDR_MOD_LO: begin
          rsel = s_q.modulo[7:0];
        end
        ADDR_DEADTIME: begin
          rsel = s_q.dead;
        end
        ADDR_CONFIG: begin
          rsel = s_q.cfg;
        end
        ADDR_INT_STS: begin
          rsel = s_q.int_sts;
        end
        ADDR_INT_MASK: begin
          rsel = s_q.int_mask;
        end
        default: begin
          if (addr_in >= ADDR_VAL_BASE && addr_in <= ADDR_VAL_LAST) begin
            vidx = 4'(addr_in - ADDR_VAL_BASE);
            rsel = vidx[0] ? s_q.val_buf[vidx[3:1]][7:0]
                           : s_q.val_buf[vidx[3:1]][15:8];
          end
        end
      endcase
    end
    s_d.rdata = rsel;

    s_d.irq = |(s_d.int_sts & s_d.int_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: design/mcp_pkg.sv
// Constants, register map and field layout of the motor control PWM core.
// Functional notes
// - Six outputs run as three complementary pairs or six independent signals.
// - Edge-aligned or center-aligned waveforms are chosen by configuration.
// - One shared 12-bit counter times all six channels.
// - Width steps are one counter period edge-aligned, two center-aligned.
// - Counter clock is the operating clock divided by a selectable prescaler.
// - Smallest prescaler at 8 MHz gives 125 ns or 250 ns steps.
// - Complementary pairs get automatic dead time; top and bottom never both active except under manual override.
// - Software selects the active polarity of the outputs.
// - Manual override lets software bits set each output level directly.
// - Complementary pairs take top or bottom width correction from sense inputs or bits.
package mcp_pkg;
  localparam logic [7:0] ADDR_MAIN_CTL  = 8'h20;
  localparam logic [7:0] ADDR_SEC_CTL   = 8'h21;
  localparam logic [7:0] ADDR_FAULT_CTL = 8'h22;
  localparam logic [7:0] ADDR_FAULT_STS = 8'h23;
  localparam logic [7:0] ADDR_FAULT_ACK = 8'h24;
  localparam logic [7:0] ADDR_MANUAL    = 8'h25;
  localparam logic [7:0] ADDR_CNT_HI    = 8'h26;
  localparam logic [7:0] ADDR_CNT_LO    = 8'h27;
  localparam logic [7:0] ADDR_MOD_HI    = 8'h28;
  localparam logic [7:0] ADDR_MOD_LO    = 8'h29;
  localparam logic [7:0] ADDR_VAL_BASE  = 8'h2a;
  localparam logic [7:0] ADDR_VAL_LAST  = 8'h35;
  localparam logic [7:0] ADDR_DEADTIME  = 8'h36;
  localparam logic [7:0] ADDR_CONFIG    = 8'h37;
  localparam logic [7:0] ADDR_INT_STS   = 8'h38;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h39;
  // Main control fields.
  localparam int MAIN_ENABLE_BIT = 0;
  localparam int MAIN_LOAD_BIT   = 1;
  localparam int MAIN_RELOAD_BIT = 4;
  // Secondary control fields.
  localparam int SEC_PRESCALE_LO  = 0;
  localparam int SEC_CORR_LO      = 2;
  localparam logic [7:0] SEC_MASK = 8'h1f;
  // Configuration fields.
  localparam int CFG_CENTER_BIT = 0;
  localparam int CFG_INDEP_BIT  = 1;
  localparam int CFG_POL_BIT    = 2;
  localparam int CFG_SENSE_BIT  = 3;
  // Fault fields.
  localparam int FLT1_EN_BIT   = 0;
  localparam int FLT4_EN_BIT   = 6;
  localparam int FLT1_FLAG_BIT = 0;
  localparam int FLT1_PIN_BIT  = 1;
  localparam int FLT4_FLAG_BIT = 6;
  localparam int FLT4_PIN_BIT  = 7;
  localparam int FLT1_ACK_BIT  = 0;
  localparam int FLT4_ACK_BIT  = 6;
  // Manual output fields.
  localparam int MAN_ENABLE_BIT = 6;
  // Interrupt status fields.
  localparam int INT_RELOAD_BIT = 0;
  localparam int INT_FLT1_BIT   = 1;
  localparam int INT_FLT4_BIT   = 2;
  localparam logic [7:0] INT_MASK_ALL = 8'h07;
  // Reset values.
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [11:0] RST_MODULO = 12'h000;
  localparam logic [15:0] RST_VALUE  = 16'h0000;
  // Timing of the finest step at the smallest prescaler.
  localparam int OP_CLOCK_MHZ   = 8;
  localparam int STEP_EDGE_NS   = 125;
  localparam int STEP_CENTER_NS = 250;
  localparam int SYS_PERIOD_NS  = 10;
  localparam int STEP_EDGE_CYC  = STEP_EDGE_NS / SYS_PERIOD_NS;
  localparam int STEP_CENTER_CYC = STEP_CENTER_NS / SYS_PERIOD_NS;
endpackage

// file: design/mcp_tb_if.sv
// Carrier between the time base and the core logic.
`timescale 1ns/1ns
`default_nettype none
interface mcp_tb_if;
  logic        enable;
  logic        center;
  logic [1:0]  prescale;
  logic [11:0] modulo;
  logic [11:0] count;
  logic        start;
  modport src (input enable, center, prescale, modulo, output count, start);
  modport use_side (output enable, center, prescale, modulo, input count, start);
endinterface
`default_nettype wire

// file: design/mcp_timebase.sv
// Prescaler and shared 12-bit up or up/down counter.
`timescale 1ns/1ns
`default_nettype none
module mcp_timebase
  import mcp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  mcp_tb_if.src     tb
);
  typedef struct packed {
    logic [7:0]  pre;
    logic [11:0] cnt;
    logic        down;
    logic        start;
  } mcp_tbst_type;
  mcp_tbst_type s_q, s_d;
  logic [7:0] pre_top;
  assign tb.count = s_q.cnt;
  assign tb.start = s_q.start;
  always_comb begin
    pre_top = 8'((1 << tb.prescale) - 1);
    s_d = s_q;
    s_d.start = 1'b0;
    if (!tb.enable) begin
      s_d = '0;
    end else if (s_q.pre != pre_top) begin
      s_d.pre = 8'(s_q.pre + 8'h01);
    end else begin
      s_d.pre = '0;
      if (tb.modulo == '0) begin
        s_d.cnt = '0;
      end else if (!tb.center) begin
        s_d.cnt = (s_q.cnt >= 12'(tb.modulo - 12'h001)) ? '0 : 12'(s_q.cnt + 12'h001);
        s_d.start = (s_d.cnt == '0);
      end else if (!s_q.down) begin
        s_d.cnt = 12'(s_q.cnt + 12'h001);
        s_d.down = (s_d.cnt >= tb.modulo);
      end else begin
        s_d.cnt = 12'(s_q.cnt - 12'h001);
        s_d.down = (s_d.cnt != '0);
        s_d.start = (s_d.cnt == '0);
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: design/mcp_deadtime.sv
// Dead-time inserter for one complementary pair.
`timescale 1ns/1ns
`default_nettype none
module mcp_deadtime (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  input  wire logic       top_in,
  input  wire logic [7:0] dead_in,
  output logic            top_out,
  output logic            bot_out
);
  typedef struct packed {
    logic       last;
    logic [7:0] cnt;
  } mcp_dtst_type;
  mcp_dtst_type s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (top_in != s_q.last) begin
      s_d.last = top_in;
      s_d.cnt = dead_in;
    end else if (s_q.cnt != 8'h00) begin
      s_d.cnt = 8'(s_q.cnt - 8'h01);
    end
  end
  assign top_out = s_q.last & (s_q.cnt == 8'h00);
  assign bot_out = ~s_q.last & (s_q.cnt == 8'h00);
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// file: test/mcp_core_checker.sv
// Concurrent checks on the ports of the PWM core.
`timescale 1ns/1ns
`default_nettype none
module mcp_core_checker
  import mcp_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [1:0] fault_in,
  input wire logic [7:0] rdata_out,
  input wire logic [5:0] pwm_out,
  input wire logic       irq_out
);
  // ----------------------------------------
  // Shadow copies of written registers.
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] man_q;
  logic [7:0] flt_q;
  logic [7:0] mask_q;
  logic [2:0] quiet_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cfg_q   <= 8'h00;
      man_q   <= 8'h00;
      flt_q   <= 8'h00;
      mask_q  <= 8'h00;
      quiet_q <= 3'h0;
    end else begin
      if (wr_in && addr_in == ADDR_CONFIG) cfg_q <= wdata_in;
      if (wr_in && addr_in == ADDR_MANUAL) man_q <= wdata_in;
      if (wr_in && addr_in == ADDR_FAULT_CTL) flt_q <= wdata_in;
      if (wr_in && addr_in == ADDR_INT_MASK) mask_q <= wdata_in;
      quiet_q <= wr_in ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
    end
  end
  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rd_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_unmapped;
    rd_in && addr_in < ADDR_MAIN_CTL |=> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ack_zero;
    rd_in && addr_in == ADDR_FAULT_ACK |=> rdata_out == 8'h00;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("write-only register read back");
  property p_cnt_hi;
    rd_in && addr_in == ADDR_CNT_HI |=> rdata_out[7:4] == 4'h0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("counter high byte too wide");
  property p_dead;
    quiet_q == 3'h7 && !cfg_q[CFG_INDEP_BIT] && !cfg_q[CFG_POL_BIT] && !man_q[MAN_ENABLE_BIT]
      |-> !(pwm_out[0] && pwm_out[1]);
  endproperty
  a_dead: assert property (p_dead) else $error("pair outputs active together");
  property p_manual;
    quiet_q >= 3'h4 && man_q[MAN_ENABLE_BIT] && cfg_q[CFG_INDEP_BIT] && flt_q == 8'h00
      |-> pwm_out == (cfg_q[CFG_POL_BIT] ? ~man_q[5:0] : man_q[5:0]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual levels not on outputs");
  property p_irq_mask;
    mask_q == 8'h00 && quiet_q >= 3'h3 |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt high while masked");
  property p_fault_off;
    (flt_q[FLT1_EN_BIT] && fault_in[0] && !cfg_q[CFG_POL_BIT])[*3] |-> ##2 pwm_out == 6'h00;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("outputs active during fault");
  property p_fault_irq;
    mask_q[INT_FLT1_BIT] && flt_q[FLT1_EN_BIT] && $rose(fault_in[0]) |-> ##[1:4] irq_out;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt missing");
endmodule
bind mcp_core mcp_core_checker chk_u (
  .clk_in    (clk_in),
  .resetn_in (resetn_in),
  .addr_in   (addr_in),
  .wdata_in  (wdata_in),
  .wr_in     (wr_in),
  .rd_in     (rd_in),
  .fault_in  (fault_in),
  .rdata_out (rdata_out),
  .pwm_out   (pwm_out),
  .irq_out   (irq_out)
);
`default_nettype wire

// file: test/mcp_inverter_model.sv
// Power stage model: fault sense and current sense back to the core.
`timescale 1ns/1ns
`default_nettype none
module mcp_inverter_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] pwm_in,
  input  wire logic       trip_in,
  input  wire logic [2:0] sense_in,
  output logic      [1:0] fault_out,
  output logic      [2:0] sense_out
);
  // Fault one follows the trip request; fault four flags shoot-through of pair 0.
  always_ff @(posedge clk_in) begin
    fault_out <= {pwm_in[0] & pwm_in[1], trip_in};
    sense_out <= sense_in;
  end
endmodule
`default_nettype wire

// file: test/motor_control_pwm_core_bench.sv
// Register-level testbench of the PWM core.
`timescale 1ns/1ns
`default_nettype none
`define MCP_CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module motor_control_pwm_core_bench;
  import mcp_pkg::*;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       ce = 1'b1;
  logic [5:0] hold;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       trip = 1'b0;
  logic [2:0] sense_req = 3'h0;
  logic [1:0] fault;
  logic [2:0] sense;
  logic [7:0] rdata;
  logic [5:0] pwm;
  logic       irq;
  int         fails = 0;
  int         compares = 0;
  int         cycles = 0;
  logic [15:0] h4, h5, r4, r5;
  logic [7:0] cfgs [3] = '{8'h02, 8'h02, 8'h03};
  logic [7:0] pres [3] = '{8'h00, 8'h01, 8'h00};
  logic [15:0] rises [3] = '{16'h0022, 16'h0011, 16'h0011};
  mcp_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .fault_in(fault), .current_sense_in(sense),
    .rdata_out(rdata), .pwm_out(pwm), .irq_out(irq));
  mcp_inverter_model inv_u (.clk_in(clk_in), .pwm_in(pwm), .trip_in(trip),
    .sense_in(sense_req), .fault_out(fault), .sense_out(sense));
  // ----------------------------------------
  // Clock, timeout and closing.
  // ----------------------------------------
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic close_out;
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------
  // Bus and measurement tasks.
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    `MCP_CHK(rdata, e)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic measure(input int b, output logic [15:0] hi, output logic [15:0] rs);
    logic prev;
    hi = 16'h0000;
    rs = 16'h0000;
    prev = pwm[b];
    repeat (272) begin
      @(posedge clk_in);
      #1;
      hi = hi + {15'h0000, pwm[b]};
      rs = rs + {15'h0000, pwm[b] & ~prev};
      prev = pwm[b];
    end
  endtask
  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(ADDR_MAIN_CTL + i[7:0], 8'h00);
    rd_chk(8'h10, 8'h00);
    wr_reg(ADDR_SEC_CTL, 8'hff);
    rd_chk(ADDR_SEC_CTL, 8'h1f);
    wr_reg(ADDR_SEC_CTL, 8'h00);
    wr_reg(ADDR_CNT_HI, 8'hff);
    rd_chk(ADDR_CNT_HI, 8'h00);
    wr_reg(ADDR_CONFIG, 8'h02);
    wr_reg(ADDR_MANUAL, 8'h6a);
    settle(4);
    `MCP_CHK(pwm, 6'h2a)
    wr_reg(ADDR_CONFIG, 8'h06);
    settle(4);
    `MCP_CHK(pwm, 6'h15)
    wr_reg(ADDR_CONFIG, 8'h02);
    wr_reg(ADDR_MANUAL, 8'h7f);
    wr_reg(ADDR_FAULT_CTL, 8'h01);
    wr_reg(ADDR_INT_MASK, 8'h02);
    @(posedge clk_in);
    trip <= 1'b1;
    settle(6);
    `MCP_CHK(pwm, 6'h00)
    `MCP_CHK(irq, 1'b1)
    rd_chk(ADDR_FAULT_STS, 8'h03);
    wr_reg(ADDR_INT_MASK, 8'h00);
    settle(3);
    `MCP_CHK(irq, 1'b0)
    wr_reg(ADDR_INT_MASK, 8'h02);
    trip <= 1'b0;
    wr_reg(ADDR_FAULT_ACK, 8'h01);
    wr_reg(ADDR_INT_STS, 8'h02);
    settle(3);
    `MCP_CHK(irq, 1'b0)
    rd_chk(ADDR_FAULT_STS, 8'h80);
    `MCP_CHK(pwm, 6'h3f)
    wr_reg(ADDR_FAULT_CTL, 8'h00);
    wr_reg(ADDR_INT_MASK, 8'h00);
    wr_reg(ADDR_MANUAL, 8'h00);
    wr_reg(ADDR_MOD_LO, 8'h08);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_CONFIG, cfgs[i]);
      wr_reg(ADDR_SEC_CTL, pres[i]);
      wr_reg(ADDR_VAL_BASE + 8'h01, 8'h04);
      wr_reg(ADDR_MAIN_CTL, 8'h03);
      settle(40);
      measure(0, h4, r4);
      wr_reg(ADDR_VAL_BASE + 8'h01, 8'h05);
      wr_reg(ADDR_MAIN_CTL, 8'h03);
      settle(40);
      measure(0, h5, r5);
      `MCP_CHK(r4, rises[i])
      `MCP_CHK(h5 - h4, 16'h0022)
    end
    wr_reg(ADDR_DEADTIME, 8'h02);
    wr_reg(ADDR_CONFIG, 8'h00);
    wr_reg(ADDR_SEC_CTL, 8'h00);
    settle(40);
    measure(0, h4, r4);
    measure(1, h5, r5);
    `MCP_CHK(h4, 16'h0066)
    `MCP_CHK(h4 + h5, 16'h0088)
    rd_chk(ADDR_MAIN_CTL, 8'h11);
    rd_chk(ADDR_MOD_LO, 8'h08);
    rd_chk(ADDR_VAL_BASE + 8'h01, 8'h05);
    rd_chk(ADDR_DEADTIME, 8'h02);
    wr_reg(ADDR_VAL_BASE + 8'h03, 8'h06);
    wr_reg(ADDR_MAIN_CTL, 8'h03);
    wr_reg(ADDR_SEC_CTL, 8'h04);
    settle(40);
    measure(0, h4, r4);
    `MCP_CHK(h4, 16'h0088)
    wr_reg(ADDR_SEC_CTL, 8'h00);
    wr_reg(ADDR_CONFIG, 8'h08);
    sense_req <= 3'h1;
    settle(40);
    measure(0, h4, r4);
    `MCP_CHK(h4, 16'h0088)
    sense_req <= 3'h0;
    settle(40);
    measure(0, h4, r4);
    `MCP_CHK(h4, 16'h0066)
    wr_reg(ADDR_INT_MASK, 8'h01);
    settle(20);
    `MCP_CHK(irq, 1'b1)
    wr_reg(ADDR_INT_MASK, 8'h00);
    wr_reg(ADDR_INT_STS, 8'h01);
    settle(3);
    `MCP_CHK(irq, 1'b0)
    @(posedge clk_in);
    ce <= 1'b0;
    settle(2);
    hold = pwm;
    settle(30);
    `MCP_CHK(pwm, hold)
    ce <= 1'b1;
    settle(20);
    measure(0, h4, r4);
    `MCP_CHK(h4, 16'h0066)
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk(ADDR_CONFIG, 8'h00);
    rd_chk(ADDR_MAIN_CTL, 8'h00);
    `MCP_CHK(pwm, 6'h00)
    `MCP_CHK(irq, 1'b0)
    close_out();
  end
endmodule
`default_nettype wire
